// [hdl/dmr_defines.svh]
// Constants for the DRAM multi-purpose register readout path
`ifndef DMR_DEFINES_SVH
`define DMR_DEFINES_SVH
`define DMR_MR3_MPR_EN_BIT  2
`define DMR_MPR_COUNT       4
`define DMR_BEATS_BL8       8
`define DMR_BEATS_BC4       4
`define DMR_BURST_BEAT_W    3
`define DMR_MPR_RESET_VAL   8'h00
`define DMR_LAT_W           6
`endif

// [hdl/dmr_pkg.sv]
// Types for the DRAM multi-purpose register readout path
package dmr_pkg;
   typedef enum logic [1:0] {DMR_MR0, DMR_MR3, DMR_MR_OTHER, DMR_MR_RSVD} dmr_mr_type;
   typedef enum {DMR_IDLE, DMR_WAIT, DMR_BURST} dmr_state_type;
endpackage

// [hdl/dmr_lane_map.sv]
// Staggered lane mapping from four MPR bytes onto the data lanes of one beat
`timescale 1ns/1ns
`default_nettype none
`include "dmr_defines.svh"
module dmr_lane_map #(
   parameter int DQ_W = 16
) (
   input  wire logic [8*`DMR_MPR_COUNT-1:0] mpr_i,   // Four MPR bytes, location 0 lowest
   input  wire logic [1:0]                  sel_i,   // Selected MPR location
   input  wire logic [2:0]                  beat_i,  // Beat (UI) index
   output logic      [DQ_W-1:0]             dq_o     // Bit for each lane
);
   generate
      if (DQ_W % `DMR_MPR_COUNT != 0)
      begin : g_bad_width
         $error("DQ_W must be a multiple of four");
      end
   endgenerate
   genvar n;
   generate
      for (n = 0; n < DQ_W; n = n + 1)
      begin : g_lane
         // Lane n takes location (sel + n) mod 4; upper byte repeats lower
         logic [1:0] loc;
         assign loc = 2'(sel_i + 2'(n % `DMR_MPR_COUNT));
         // UI0 carries the MSB of the byte
         assign dq_o[n] = mpr_i[8*loc + 3'(7 - beat_i)];
      end
   endgenerate
endmodule
`default_nettype wire

// [hdl/dmr_readout.sv]
// MPR mode control and staggered readout burst generator
`timescale 1ns/1ns
`default_nettype none
`include "dmr_defines.svh"
// Functional notes
// - Lane n of the lower byte carries location (n mod 4) for MPR0, upper byte repeats it.
// - A mode write to MR3 with bit A2 set enables MPR mode and redirects reads to the MPRs.
// - The controller drives A2 low and BL8 beats come back in order 0 to 7.
// - Only BA1 and BA0 select the MPR location on a read.
// - A10, BG0 and other unassigned address pins are ignored on an MPR read.
// - A mode write to MR3 with A2 clear leaves MPR mode and restores array access.
// - With parity latency mode on, parity latency adds to read-to-data delay.
// - Bank address 00..11 selects MPR location 0..3.
// - In burst chop four, beats 0 to 3 are driven and the last four are not.
module dmr_readout #(
   parameter int DQ_W = 16
) (
   input  wire logic                        clk_i,         // Clock
   input  wire logic                        resetn_i,      // Async reset, active low
   input  wire logic                        mrs_i,         // Mode register set pulse
   input  wire logic [1:0]                  mrs_sel_i,     // Mode register selected
   input  wire logic [17:0]                 addr_i,        // Address pins A[17:0]
   input  wire logic                        rd_i,          // Read command pulse
   input  wire logic [1:0]                  ba_i,          // Bank address BA[1:0]
   input  wire logic                        bg_i,          // Bank group BG0
   input  wire logic [8*`DMR_MPR_COUNT-1:0] mpr_i,         // MPR page contents
   input  wire logic [`DMR_LAT_W-1:0]       rd_lat_i,      // Read latency in beats, >= 1
   input  wire logic [`DMR_LAT_W-1:0]       par_lat_i,     // Parity latency in beats
   input  wire logic                        par_en_i,      // Parity latency mode enabled
   output logic                             mpr_mode_o,    // MPR mode active
   output logic                             array_rd_o,    // Read passed to the array
   output logic [DQ_W-1:0]                  dq_o,          // Data lanes
   output logic [DQ_W-1:0]                  dq_oe_o,       // Lane output enables
   output logic                             burst_start_o  // First beat strobe
);
   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   // Lanes rotate through four locations; a partial group of lanes has no defined pattern
   generate
      if (DQ_W < `DMR_MPR_COUNT || DQ_W % `DMR_MPR_COUNT != 0)
      begin : g_bad_width
         $error("DQ_W must be a nonzero multiple of four");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Mode registers
   // ----------------------------------------------------------------
   logic       mpr_mode;
   logic       bc4_fixed;
   logic       bl_otf;
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         mpr_mode <= 1'b0;
      else if (mrs_i && mrs_sel_i == dmr_pkg::DMR_MR3)
         mpr_mode <= addr_i[`DMR_MR3_MPR_EN_BIT];
   end

   // The mode flop is the status output itself, so status and read routing never disagree
   assign mpr_mode_o = mpr_mode;

   // MR0 A[1:0]: 00 fixed BL8, 01 on the fly, 10 fixed BC4
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         bc4_fixed <= 1'b0;
         bl_otf    <= 1'b0;
      end
      else if (mrs_i && mrs_sel_i == dmr_pkg::DMR_MR0)
      begin
         bc4_fixed <= addr_i[1:0] == 2'h2;
         bl_otf    <= addr_i[1:0] == 2'h1;
      end
   end

   // ----------------------------------------------------------------
   // Read capture
   // ----------------------------------------------------------------
   // A12 low on the fly would request BC4; with A12 high it is BL8.
   logic next_bc4;
   assign next_bc4 = bc4_fixed | (bl_otf & ~addr_i[12]);

   dmr_pkg::dmr_state_type           state;
   logic [1:0]                       sel;
   logic                             bc4;
   logic [`DMR_LAT_W:0]              wait_cnt;
   logic [`DMR_BURST_BEAT_W-1:0]     beat;
   logic [`DMR_LAT_W:0]              total_lat;
   // Only BA selects; A10, BG0 and other address bits besides A12 are never looked at on a read
   assign total_lat = {1'b0, rd_lat_i} + (par_en_i ? {1'b0, par_lat_i} : 7'h00);

   // A new read during a wait or a burst is ignored; back-to-back needs a pipeline
   logic rd_take;
   logic last_beat;
   assign rd_take   = state == dmr_pkg::DMR_IDLE && rd_i && mpr_mode;
   assign last_beat = beat == 3'(`DMR_BEATS_BL8 - 1);

   // ----------------------------------------------------------------
   // Burst sequencing
   // ----------------------------------------------------------------
   // A latency of zero behaves as one; the burst always takes eight cycles
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         state <= dmr_pkg::DMR_IDLE;
      else
      begin
         unique case (state)
            dmr_pkg::DMR_IDLE:
            begin
               if (rd_take)
                  state <= (total_lat <= 7'h01) ? dmr_pkg::DMR_BURST
                                                : dmr_pkg::DMR_WAIT;
            end
            dmr_pkg::DMR_WAIT:
            begin
               if (wait_cnt == 7'h02)
                  state <= dmr_pkg::DMR_BURST;
            end
            dmr_pkg::DMR_BURST:
            begin
               if (last_beat)
                  state <= dmr_pkg::DMR_IDLE;
            end
         endcase
      end
   end

   // Location and burst chop are taken with the command and held for the whole burst
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         sel <= 2'h0;
         bc4 <= 1'b0;
      end
      else if (rd_take)
      begin
         sel <= ba_i;
         bc4 <= next_bc4;
      end
   end

   // Latency counter, loaded with the full latency when the command is taken
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         wait_cnt <= 7'h00;
      else if (rd_take)
         wait_cnt <= total_lat;
      else if (state == dmr_pkg::DMR_WAIT)
         wait_cnt <= wait_cnt - 7'h01;
   end

   // Beat counter: the burst order is fixed and always starts at beat 0
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         beat <= 3'h0;
      else if (rd_take)
         beat <= 3'h0;
      else if (state == dmr_pkg::DMR_BURST)
         beat <= beat + 3'h1;
   end

   // ----------------------------------------------------------------
   // Data lanes
   // ----------------------------------------------------------------
   logic [DQ_W-1:0] lane_bits;
   dmr_lane_map #(.DQ_W(DQ_W)) u_map (
      .mpr_i  (mpr_i),
      .sel_i  (sel),
      .beat_i (beat),
      .dq_o   (lane_bits)
   );

   logic drive;
   assign drive = state == dmr_pkg::DMR_BURST
                  && !(bc4 && beat >= 3'(`DMR_BEATS_BC4));

   // Lanes are held low while not driven so a released bus never shows stale data
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         dq_o    <= '0;
         dq_oe_o <= '0;
      end
      else
      begin
         dq_o    <= drive ? lane_bits : '0;
         dq_oe_o <= {DQ_W{drive}};
      end
   end

   // ----------------------------------------------------------------
   // Status strobes
   // ----------------------------------------------------------------
   // Marks the first beat on the lanes, in the same cycle as that beat
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         burst_start_o <= 1'b0;
      else
         burst_start_o <= state == dmr_pkg::DMR_BURST && beat == 3'h0;
   end

   // Reads outside MPR mode go on to the array; in MPR mode they never reach it
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         array_rd_o <= 1'b0;
      else
         array_rd_o <= rd_i && !mpr_mode;
   end
endmodule
`default_nettype wire

// [tb/dmr_ctl_model.sv]
// Controller model that issues mode writes and reads
`timescale 1ns/1ns
`default_nettype none
module dmr_ctl_model (
   input  wire logic        clk_i,     // Clock
   output var  logic        mrs_o,     // Mode write
   output var  logic [1:0]  mrs_sel_o, // Register
   output var  logic [17:0] addr_o,    // Address
   output var  logic        rd_o,      // Read
   output var  logic [1:0]  ba_o,      // Bank
   output var  logic        bg_o       // Group
);
   initial {mrs_o, rd_o, mrs_sel_o, addr_o, ba_o, bg_o} = '0;
   // Idle address and bank lines show the inverse of the last command; mrs_sel_o and bg_o keep their command values
   task automatic cmd(input logic m, input logic [1:0] s, input logic [17:0] a,
                      input logic [1:0] b);
      @(posedge clk_i);
      #1;
      {mrs_o, rd_o, mrs_sel_o, addr_o, ba_o} = {m, !m, s, a, b};
      bg_o = ~bg_o;
      @(posedge clk_i);
      #1;
      {mrs_o, rd_o, addr_o, ba_o} = {2'b00, ~addr_o, ~ba_o};
   endtask
   task automatic rd(input logic [1:0] b, input logic a12);
      cmd(1'b0, 2'h1, {5'h00, a12, 2'b01, 10'h000}, b);
   endtask
endmodule
`default_nettype wire

// [tb/dmr_readout_props.sv]
// Checker for the MPR readout path
`timescale 1ns/1ns
`default_nettype none
module dmr_props (
   input wire logic        clk_i,        // Clock
   input wire logic        resetn_i,     // Reset
   input wire logic        mrs_i,        // Mode write
   input wire logic [1:0]  mrs_sel_i,    // Register
   input wire logic [17:0] addr_i,       // Address
   input wire logic        rd_i,         // Read
   input wire logic        par_en_i,     // Parity
   input wire logic        mpr_mode_o,   // Mode
   input wire logic        array_rd_o,   // Array read
   input wire logic [15:0] dq_o,         // Data
   input wire logic [15:0] dq_oe_o,      // Enables
   input wire logic        burst_start_o // Start
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   sequence s_mr3; mrs_i && mrs_sel_i == 2'h1; endsequence
   sequence s_tail; !burst_start_o [*7] ##1 !dq_oe_o[0]; endsequence
   property p_on; s_mr3 ##0 addr_i[2] |=> mpr_mode_o; endproperty
   a_on: assert property (p_on) else $error("mode not on");
   property p_off; s_mr3 ##0 !addr_i[2] |=> !mpr_mode_o; endproperty
   a_off: assert property (p_off) else $error("mode not off");
   property p_noarr; rd_i && mpr_mode_o |=> !array_rd_o; endproperty
   a_noarr: assert property (p_noarr) else $error("array read in mode");
   property p_arr; rd_i && !mpr_mode_o |=> array_rd_o; endproperty
   a_arr: assert property (p_arr) else $error("array read lost");
   property p_up; dq_oe_o[0] |-> dq_o[15:8] == dq_o[7:0] && dq_oe_o == 16'hFFFF; endproperty
   a_up: assert property (p_up) else $error("upper byte differs");
   property p_end; burst_start_o |=> s_tail; endproperty
   a_end: assert property (p_end) else $error("burst too long");
   property p_idle; !dq_oe_o[0] |-> dq_o == 16'h0000; endproperty
   a_idle: assert property (p_idle) else $error("lanes driven idle");
   // Bench runs read latency 3 and parity latency 2
   property p_lat; $rose(burst_start_o) |-> (par_en_i ? $past(rd_i, 6) : $past(rd_i, 4)); endproperty
   a_lat: assert property (p_lat) else $error("wrong latency");
endmodule
bind dmr_readout dmr_props u_props (
   .clk_i         (clk_i),
   .resetn_i      (resetn_i),
   .mrs_i         (mrs_i),
   .mrs_sel_i     (mrs_sel_i),
   .addr_i        (addr_i),
   .rd_i          (rd_i),
   .par_en_i      (par_en_i),
   .mpr_mode_o    (mpr_mode_o),
   .array_rd_o    (array_rd_o),
   .dq_o          (dq_o),
   .dq_oe_o       (dq_oe_o),
   .burst_start_o (burst_start_o)
);
`default_nettype wire

// [tb/dmr_readout_tb_top.sv]
// Self-checking testbench for the MPR readout path
`timescale 1ns/1ns
`default_nettype none
module dmr_readout_tb_top;
   logic        clk_i, resetn_i, mrs_i, rd_i, bg_i, par_en_i;
   logic        mpr_mode_o, array_rd_o, burst_start_o;
   logic [1:0]  mrs_sel_i, ba_i;
   logic [17:0] addr_i;
   logic [31:0] mpr_i;
   logic [5:0]  rd_lat_i = 6'h03;
   logic [5:0]  par_lat_i = 6'h02;
   logic [15:0] dq_o, dq_oe_o;
   int          error_cnt = 0;
   int          checks = 0;
   dmr_readout u_dut (
      .clk_i         (clk_i),
      .resetn_i      (resetn_i),
      .mrs_i         (mrs_i),
      .mrs_sel_i     (mrs_sel_i),
      .addr_i        (addr_i),
      .rd_i          (rd_i),
      .ba_i          (ba_i),
      .bg_i          (bg_i),
      .mpr_i         (mpr_i),
      .rd_lat_i      (rd_lat_i),
      .par_lat_i     (par_lat_i),
      .par_en_i      (par_en_i),
      .mpr_mode_o    (mpr_mode_o),
      .array_rd_o    (array_rd_o),
      .dq_o          (dq_o),
      .dq_oe_o       (dq_oe_o),
      .burst_start_o (burst_start_o)
   );
   dmr_ctl_model u_ctl (.clk_i(clk_i), .mrs_o(mrs_i), .mrs_sel_o(mrs_sel_i), .addr_o(addr_i),
                        .rd_o(rd_i), .ba_o(ba_i), .bg_o(bg_i));
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks=%0d errors=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic mpr_rd(input logic [1:0] b, input logic a12, input int nb);
      int n;
      logic [15:0] e;
      u_ctl.rd(b, a12);
      chk({15'h0000, array_rd_o}, 16'h0000);
      n = 0;
      while (burst_start_o !== 1'b1 && n < 20)
      begin
         @(posedge clk_i);
         #1;
         n++;
      end
      chk(n[15:0], 16'(rd_lat_i) + (par_en_i ? 16'(par_lat_i) : 16'h0000));
      for (int k = 0; k < 8; k++)
      begin
         for (int l = 0; l < 16; l++)
            e[l] = mpr_i[8 * ((b + l) % 4) + 7 - k];
         chk(dq_o, k < nb ? e : 16'h0000);
         chk(dq_oe_o, k < nb ? 16'hFFFF : 16'h0000);
         @(posedge clk_i);
         #1;
      end
      $display("read test done ba=%0d", b);
   endtask
   initial
   begin
      {resetn_i, par_en_i} = 2'b00;
      mpr_i = 32'hC35A_0FF0;
      repeat (2) @(posedge clk_i);
      #1;
      resetn_i = 1'b1;
      u_ctl.rd(2'h0, 1'b1);
      chk({15'h0000, array_rd_o}, 16'h0001);
      u_ctl.cmd(1'b1, 2'h0, 18'h00000, 2'h0);
      u_ctl.cmd(1'b1, 2'h1, 18'h00004, 2'h0);
      chk({15'h0000, mpr_mode_o}, 16'h0001);
      for (int i = 0; i < 4; i++)
      begin
         par_en_i = i[0];
         mpr_rd(i[1:0], 1'b0, 8);
      end
      mpr_i = 32'h9617_E43B;
      u_ctl.cmd(1'b1, 2'h0, 18'h00002, 2'h0);
      mpr_rd(2'h3, 1'b0, 4);
      u_ctl.cmd(1'b1, 2'h0, 18'h00001, 2'h0);
      mpr_rd(2'h2, 1'b1, 8);
      u_ctl.cmd(1'b1, 2'h1, 18'h00000, 2'h0);
      u_ctl.rd(2'h1, 1'b0);
      chk({15'h0000, array_rd_o}, 16'h0001);
      $display("mode exit test done");
      u_ctl.cmd(1'b1, 2'h1, 18'h00004, 2'h0);
      resetn_i = 1'b0;
      @(posedge clk_i);
      #1;
      chk({15'h0000, mpr_mode_o}, 16'h0000);
      resetn_i = 1'b1;
      u_ctl.rd(2'h0, 1'b1);
      chk({15'h0000, array_rd_o}, 16'h0001);
      $display("reset test done");
      end_of_test();
   end
   initial
   begin
      #5000;
      error_cnt++;
      end_of_test();
   end
endmodule
`default_nettype wire
